// [common/uart_msr_consts.svh]
// Purpose: register offsets, field positions, reset values
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes:   one 8-bit register per aligned word, data in bits 7:0
`ifndef UART_MSR_CONSTS_SVH
`define UART_MSR_CONSTS_SVH

`define OFS_MODEM_STATUS   6'h00
`define OFS_SCRATCH_PAD    6'h04
`define OFS_DIVISOR_LOW    6'h08
`define OFS_DIVISOR_HIGH   6'h0C
`define OFS_DIVISOR_FRAC   6'h10
`define OFS_PART_ID        6'h14
`define OFS_PART_REV       6'h18
`define OFS_ENH_FEATURE    6'h1C
`define OFS_RESUME1        6'h20
`define OFS_RESUME2        6'h24
`define OFS_STOP1          6'h28
`define OFS_STOP2          6'h2C
`define OFS_MODEM_CONTROL  6'h30
`define OFS_INT_ENABLE     6'h34
`define OFS_FIFO_CONTROL   6'h38
`define OFS_INT_STATUS     6'h3C

`define ENH_GATE_BIT       4
`define SPECIAL_DET_BIT    5
`define AUTO_CTS_BIT       7
`define LOOPBACK_BIT       4
`define MODEM_IRQ_EN_BIT   3
`define CHAR_IRQ_EN_BIT    5
`define SPECIAL_FLAG_BIT   4
`define STOP_FLAG_BIT      5

`define SCRATCH_RST        8'hFF
`define DIV_LOW_RST        8'h01
`define DIV_HIGH_RST       8'h00
`define ZERO_BYTE          8'h00
`define PART_ID_DEFAULT    8'h5A
`define PART_REV_DEFAULT   8'h0C

`endif

// [common/uart_msr_pkg.sv]
// Purpose: shared types of the modem status and flow control block
// Assumes: nothing
// Notes:   flow_sel_t order follows the two-bit select field code
package uart_msr_pkg;
  typedef enum logic [1:0] {FLOW_NONE, FLOW_SECOND, FLOW_FIRST, FLOW_BOTH} flow_sel_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RESUME1, SEQ_STOP1} seq_state_t;
endpackage

// [common/char_match_if.sv]
// Purpose: carries received characters and flow settings to the matcher
// Assumes: one clock domain
// Notes:   hits are combinational, valid in the rx_valid cycle
`timescale 1ns/1ps
interface char_match_if;
  import uart_msr_pkg::*;
  logic       rx_valid;
  logic [7:0] rx_data;
  flow_sel_t  tx_sel;
  flow_sel_t  rx_sel;
  logic [7:0] resume1;
  logic [7:0] resume2;
  logic [7:0] stop1;
  logic [7:0] stop2;
  logic       resume_hit;
  logic       stop_hit;
  modport ctrl  (output rx_valid, rx_data, tx_sel, rx_sel, resume1, resume2,
                 stop1, stop2, input resume_hit, stop_hit);
  modport match (input rx_valid, rx_data, tx_sel, rx_sel, resume1, resume2,
                 stop1, stop2, output resume_hit, stop_hit);
endinterface

// [rtl/flow_char_match.sv]
// Purpose: compares received characters with resume and stop characters
// Assumes: rx_valid is a one-cycle strobe on ref_clk
// Notes:   dual mode waits for the first character, then the second
`timescale 1ns/1ps
module flow_char_match
  import uart_msr_pkg::*;
(
  input wire logic   ref_clk,
  input wire logic   nrst,
  char_match_if.match m
);
  seq_state_t seq_r;
  seq_state_t seq_nxt;
  logic       dual;

  // single pair selection uses either character alone
  assign dual = (m.rx_sel == FLOW_BOTH) &&
                ((m.tx_sel == FLOW_BOTH) || (m.tx_sel == FLOW_NONE));

  // hit decode per receive selection
  always_comb
  begin
    m.resume_hit = 1'b0;
    m.stop_hit   = 1'b0;
    unique case (m.rx_sel)
      FLOW_NONE:
      begin
        m.resume_hit = 1'b0;
      end
      FLOW_FIRST:
      begin
        m.resume_hit = m.rx_data == m.resume1;
        m.stop_hit   = m.rx_data == m.stop1;
      end
      FLOW_SECOND:
      begin
        m.resume_hit = m.rx_data == m.resume2;
        m.stop_hit   = m.rx_data == m.stop2;
      end
      FLOW_BOTH:
      begin
        if (dual)
        begin
          m.resume_hit = (seq_r == SEQ_RESUME1) && (m.rx_data == m.resume2);
          m.stop_hit   = (seq_r == SEQ_STOP1) && (m.rx_data == m.stop2);
        end
        else
        begin
          m.resume_hit = (m.rx_data == m.resume1) || (m.rx_data == m.resume2);
          m.stop_hit   = (m.rx_data == m.stop1) || (m.rx_data == m.stop2);
        end
      end
    endcase
    m.resume_hit = m.resume_hit && m.rx_valid;
    m.stop_hit   = m.stop_hit && m.rx_valid;
  end

  // remembers a first character of a pair; anything else restarts
  always_comb
  begin
    seq_nxt = seq_r;
    if (!dual)
      seq_nxt = SEQ_IDLE;
    else if (m.rx_valid)
    begin
      if (m.rx_data == m.resume1)
        seq_nxt = SEQ_RESUME1;
      else if (m.rx_data == m.stop1)
        seq_nxt = SEQ_STOP1;
      else
        seq_nxt = SEQ_IDLE;
    end
  end

  // sequence state
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      seq_r <= SEQ_IDLE;
    else
      seq_r <= seq_nxt;
  end
endmodule // flow_char_match

// [rtl/uart_modem_flowctl.sv]
// Purpose: modem status, divisor, ident and enhanced flow control regs
// Assumes: classic wishbone slave, byte 0 lane, 40 MHz ref_clk
// Notes:   answers every access with ack one cycle after it is seen
`timescale 1ns/1ps
`include "uart_msr_consts.svh"
module uart_modem_flowctl
  import uart_msr_pkg::*;
#(
  parameter logic [7:0] PART_ID  = `PART_ID_DEFAULT,  // arbitrary value
  parameter logic [7:0] PART_REV = `PART_REV_DEFAULT  // arbitrary value
)(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             op2_n,
  input  wire logic        tx_char_busy,
  output logic             tx_hold,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_store,
  output logic      [7:0]  rx_store_data,
  output logic             resume_seen,
  output logic             stop_seen,
  output logic      [1:0]  tx_flow_mode,
  output logic      [15:0] resume_chars,
  output logic      [15:0] stop_chars,
  output logic      [15:0] baud_int,
  output logic      [3:0]  baud_frac,
  output logic      [1:0]  sample_sel,
  output logic             prescale_div4,
  output logic             xon_any,
  output logic             irda_en,
  output logic      [7:0]  int_enable,
  output logic      [1:0]  fifo_enh,
  output logic             modem_irq,
  output logic             char_irq
);
  logic [7:0] scratch_r;
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [7:0] frac_r;
  logic [7:0] efr_r;
  logic [7:0] mcr_r;
  logic [7:0] ier_r;
  logic [1:0] fcr_enh_r;
  logic [1:0] isr_evt_r;
  logic [1:0] isr_evt_nxt;
  logic [7:0] resume1_r;
  logic [7:0] resume2_r;
  logic [7:0] stop1_r;
  logic [7:0] stop2_r;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [3:0] level_prev_r;
  logic [3:0] level_now;
  logic [3:0] delta_r;
  logic [3:0] delta_nxt;
  logic [3:0] delta_evt;
  logic       ack_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       tx_hold_r;
  logic       rx_store_r;
  logic [7:0] rx_store_data_r;
  logic       resume_seen_r;
  logic       stop_seen_r;
  logic       access;
  logic       wr;
  logic       rd;
  logic       enh;
  logic       special_hit;
  logic       drop_char;
  logic       stop_evt;

  char_match_if cm ();

  // one access per request, answered one cycle later
  assign access = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr     = access && wb_we_i && wb_sel_i[0];
  assign rd     = access && !wb_we_i;
  assign enh    = efr_r[`ENH_GATE_BIT];

  // pins are asynchronous: two flops before any use
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_r <= 4'hF;
      pin_sync_r <= 4'hF;
    end
    else
    begin
      pin_meta_r <= {cd_n, ri_n, dsr_n, cts_n};
      pin_sync_r <= pin_meta_r;
    end
  end

  // status levels, order carrier, ring, dsr, cts
  always_comb
  begin
    if (mcr_r[`LOOPBACK_BIT])
      level_now = {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]};
    else
      level_now = ~pin_sync_r;
  end

  // ring flags only the end of ringing, i.e. status high to low
  assign delta_evt[0] = level_prev_r[0] != level_now[0];
  assign delta_evt[1] = level_prev_r[1] != level_now[1];
  assign delta_evt[2] = level_prev_r[2] && !level_now[2];
  assign delta_evt[3] = level_prev_r[3] != level_now[3];

  // a change landing on the read edge survives the clear
  always_comb
  begin
    delta_nxt = delta_r;
    if (rd && wb_adr_i == `OFS_MODEM_STATUS)
      delta_nxt = 4'h0;
    delta_nxt = delta_nxt | delta_evt;
  end

  // change flags and last seen levels
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      delta_r      <= 4'h0;
      level_prev_r <= 4'h0;
    end
    else
    begin
      delta_r      <= delta_nxt;
      level_prev_r <= level_now;
    end
  end

  // plain software registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scratch_r  <= `SCRATCH_RST;
      div_low_r  <= `DIV_LOW_RST;
      div_high_r <= `DIV_HIGH_RST;
      efr_r      <= `ZERO_BYTE;
      resume1_r  <= `ZERO_BYTE;
      resume2_r  <= `ZERO_BYTE;
      stop1_r    <= `ZERO_BYTE;
      stop2_r    <= `ZERO_BYTE;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        `OFS_SCRATCH_PAD:  scratch_r  <= wb_dat_i[7:0];
        `OFS_DIVISOR_LOW:  div_low_r  <= wb_dat_i[7:0];
        `OFS_DIVISOR_HIGH: div_high_r <= wb_dat_i[7:0];
        `OFS_ENH_FEATURE:  efr_r      <= wb_dat_i[7:0];
        `OFS_RESUME1:      resume1_r  <= wb_dat_i[7:0];
        `OFS_RESUME2:      resume2_r  <= wb_dat_i[7:0];
        `OFS_STOP1:        stop1_r    <= wb_dat_i[7:0];
        `OFS_STOP2:        stop2_r    <= wb_dat_i[7:0];
        default:           scratch_r  <= scratch_r;
      endcase
    end
  end

  // enhanced-gated fields hold their value while the gate is low,
  // so legacy drivers cannot disturb them
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frac_r    <= `ZERO_BYTE;
      mcr_r     <= `ZERO_BYTE;
      ier_r     <= `ZERO_BYTE;
      fcr_enh_r <= 2'h0;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        `OFS_DIVISOR_FRAC:
        begin
          if (enh)
            frac_r <= wb_dat_i[7:0];
        end
        `OFS_MODEM_CONTROL:
        begin
          mcr_r[4:0] <= wb_dat_i[4:0];
          if (enh)
            mcr_r[7:5] <= wb_dat_i[7:5];
        end
        `OFS_INT_ENABLE:
        begin
          ier_r[3:0] <= wb_dat_i[3:0];
          if (enh)
            ier_r[7:4] <= wb_dat_i[7:4];
        end
        `OFS_FIFO_CONTROL:
        begin
          if (enh)
            fcr_enh_r <= wb_dat_i[5:4];
        end
        default:
        begin
          frac_r <= frac_r;
        end
      endcase
    end
  end

  // character status bits; write-one clears, gated, an event wins
  always_comb
  begin
    isr_evt_nxt = isr_evt_r;
    if (wr && enh && wb_adr_i == `OFS_INT_STATUS)
      isr_evt_nxt = isr_evt_r & ~wb_dat_i[5:4];
    if (special_hit)
      isr_evt_nxt[0] = 1'b1;
    if (stop_evt)
      isr_evt_nxt[1] = 1'b1;
  end

  // status event bits
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      isr_evt_r <= 2'h0;
    else
      isr_evt_r <= isr_evt_nxt;
  end

  // read mux; identity reads only with a zero divisor
  always_comb
  begin
    rdata_nxt = `ZERO_BYTE;
    unique case (wb_adr_i)
      `OFS_MODEM_STATUS:  rdata_nxt = {level_now, delta_r};
      `OFS_SCRATCH_PAD:   rdata_nxt = scratch_r;
      `OFS_DIVISOR_LOW:   rdata_nxt = div_low_r;
      `OFS_DIVISOR_HIGH:  rdata_nxt = div_high_r;
      `OFS_DIVISOR_FRAC:  rdata_nxt = enh ? frac_r : `ZERO_BYTE;
      `OFS_PART_ID:
        rdata_nxt = ({div_high_r, div_low_r} == 16'h0000) ? PART_ID : `ZERO_BYTE;
      `OFS_PART_REV:
        rdata_nxt = ({div_high_r, div_low_r} == 16'h0000) ? PART_REV : `ZERO_BYTE;
      `OFS_ENH_FEATURE:   rdata_nxt = efr_r;
      `OFS_RESUME1:       rdata_nxt = resume1_r;
      `OFS_RESUME2:       rdata_nxt = resume2_r;
      `OFS_STOP1:         rdata_nxt = stop1_r;
      `OFS_STOP2:         rdata_nxt = stop2_r;
      `OFS_MODEM_CONTROL: rdata_nxt = mcr_r;
      `OFS_INT_ENABLE:    rdata_nxt = ier_r;
      `OFS_FIFO_CONTROL:  rdata_nxt = {2'h0, fcr_enh_r, 4'h0};
      `OFS_INT_STATUS:    rdata_nxt = {2'h0, isr_evt_r, 4'h0};
      default:            rdata_nxt = `ZERO_BYTE;
    endcase
  end

  // bus answer; unmapped addresses ack with zero data
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= `ZERO_BYTE;
    end
    else
    begin
      ack_r <= access;
      if (rd)
        rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h000000, rdata_r};

  // auto cts: stop only at a character boundary, resume at once
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tx_hold_r <= 1'b0;
    else if (!efr_r[`AUTO_CTS_BIT] || level_now[0])
      tx_hold_r <= 1'b0;
    else if (!tx_char_busy)
      tx_hold_r <= 1'b1;
  end

  // matcher hookup
  assign cm.rx_valid = rx_valid;
  assign cm.rx_data  = rx_data;
  assign cm.tx_sel   = flow_sel_t'(efr_r[3:2]);
  assign cm.rx_sel   = flow_sel_t'(efr_r[1:0]);
  assign cm.resume1  = resume1_r;
  assign cm.resume2  = resume2_r;
  assign cm.stop1    = stop1_r;
  assign cm.stop2    = stop2_r;

  flow_char_match u_match (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .m       (cm)
  );

  // special detect compares the whole byte, bit 0 as lsb
  assign special_hit = rx_valid && efr_r[`SPECIAL_DET_BIT] && (rx_data == stop2_r);
  assign drop_char   = special_hit && (cm.rx_sel == FLOW_SECOND);
  assign stop_evt    = cm.stop_hit;

  // receive side strobes, one cycle behind the character
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_store_r      <= 1'b0;
      rx_store_data_r <= `ZERO_BYTE;
      resume_seen_r   <= 1'b0;
      stop_seen_r     <= 1'b0;
    end
    else
    begin
      rx_store_r    <= rx_valid && !drop_char;
      resume_seen_r <= cm.resume_hit;
      stop_seen_r   <= cm.stop_hit;
      if (rx_valid)
        rx_store_data_r <= rx_data;
    end
  end

  // outputs toward the rest of the channel
  assign tx_hold       = tx_hold_r;
  assign rx_store      = rx_store_r;
  assign rx_store_data = rx_store_data_r;
  assign resume_seen   = resume_seen_r;
  assign stop_seen     = stop_seen_r;
  assign dtr_n         = ~mcr_r[0];
  assign rts_n         = ~mcr_r[1];
  assign op2_n         = ~mcr_r[3];
  assign tx_flow_mode  = efr_r[3:2];
  assign resume_chars  = {resume1_r, resume2_r};
  assign stop_chars    = {stop1_r, stop2_r};
  assign baud_int      = {div_high_r, div_low_r};
  assign baud_frac     = frac_r[3:0];
  assign sample_sel    = frac_r[5] ? 2'h2 : {1'b0, frac_r[4]};
  assign prescale_div4 = mcr_r[7];
  assign irda_en       = mcr_r[6];
  assign xon_any       = mcr_r[5];
  assign int_enable    = ier_r;
  assign fifo_enh      = fcr_enh_r;

  // interrupt requests to the channel interrupt logic
  assign modem_irq = ier_r[`MODEM_IRQ_EN_BIT] && (delta_r != 4'h0);
  assign char_irq  = ier_r[`CHAR_IRQ_EN_BIT] && (isr_evt_r != 2'h0);
endmodule // uart_modem_flowctl

// [tb/modem_partner.sv]
// Purpose: far-end modem driving the four modem status lines
// Assumes: lines are active low and idle high
// Notes:   lines change only just after a clock edge
`timescale 1ns/1ps
module modem_partner (
  input  wire logic ref_clk,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      cd_n
);
  // idle high: nothing asserted until the far end says so
  initial {cd_n, ri_n, dsr_n, cts_n} = 4'hF;

  // order {cd, ri, dsr, cts}, applied after an edge
  task automatic set_lines(input logic [3:0] v);
    @(posedge ref_clk);
    {cd_n, ri_n, dsr_n, cts_n} <= v;
  endtask
endmodule // modem_partner

// [tb/uart_modem_flowctl_properties.sv]
// Purpose: port-level properties of the modem status and flow block
// Assumes: bound to uart_modem_flowctl
// Notes:   register effects seen one cycle after the take edge
`timescale 1ns/1ps
`include "uart_msr_consts.svh"
module uart_modem_flowctl_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_char_busy,
  input wire logic        tx_hold,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_store,
  input wire logic [7:0]  rx_store_data,
  input wire logic        stop_seen,
  input wire logic [1:0]  tx_flow_mode,
  input wire logic [15:0] baud_int,
  input wire logic [7:0]  int_enable,
  input wire logic        modem_irq,
  input wire logic        char_irq
);
  logic take_w;
  // write taken at this edge on byte lane 0
  assign take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ack_after_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after take");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  flow_mode_a: assert property (
    take_w && wb_adr_i == `OFS_ENH_FEATURE |=> tx_flow_mode == $past(wb_dat_i[3:2]))
    else $error("transmit flow mode not taken");
  div_low_a: assert property (
    take_w && wb_adr_i == `OFS_DIVISOR_LOW |=> baud_int[7:0] == $past(wb_dat_i[7:0]))
    else $error("divisor low byte not taken");
  div_high_a: assert property (
    take_w && wb_adr_i == `OFS_DIVISOR_HIGH |=> baud_int[15:8] == $past(wb_dat_i[7:0]))
    else $error("divisor high byte not taken");
  hold_after_char_a: assert property ($rose(tx_hold) |-> !$past(tx_char_busy))
    else $error("hold raised mid character");
  store_cause_a: assert property (
    rx_store |-> $past(rx_valid) && rx_store_data == $past(rx_data))
    else $error("store without matching character");
  stop_cause_a: assert property (stop_seen |-> $past(rx_valid))
    else $error("stop seen without character");
  modem_irq_gate_a: assert property (modem_irq |-> int_enable[3])
    else $error("modem irq while disabled");
  char_irq_gate_a: assert property (char_irq |-> int_enable[5])
    else $error("char irq while disabled");

  cover property (rx_valid ##1 stop_seen);
  cover property ($rose(tx_hold));
  cover property ($rose(modem_irq));
endmodule // uart_modem_flowctl_chk

bind uart_modem_flowctl uart_modem_flowctl_chk chk (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_char_busy, .tx_hold,
  .rx_valid, .rx_data, .rx_store, .rx_store_data, .stop_seen, .tx_flow_mode, .baud_int,
  .int_enable, .modem_irq, .char_irq);

// [tb/test_uart_modem_flowctl.sv]
// Purpose: register-level test of the modem status and flow block
// Assumes: classic wishbone, ack one cycle after the take edge
// Notes:   pin changes wait five cycles for the synchronisers
`timescale 1ns/1ps
`include "uart_msr_consts.svh"
module test_uart_modem_flowctl;
  localparam logic [7:0] ID_VAL  = 8'h3C; // arbitrary value
  localparam logic [7:0] REV_VAL = 8'h71; // arbitrary value
  // pins {cd, ri, dsr, cts} and the status each step must show
  localparam logic [3:0] PINS [8] = '{4'hE, 4'hE, 4'hC, 4'h8, 4'h0, 4'h4, 4'hC, 4'hF};
  localparam logic [7:0] STATUS_EXP [8] = '{8'h11, 8'h10, 8'h32, 8'h70, 8'hF8, 8'hB4, 8'h38,
                                            8'h03};
  logic        ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_char_busy, tx_hold;
  logic        cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, op2_n;
  logic        rx_valid, rx_store, stop_seen, modem_irq, char_irq;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, baud_frac;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0]  rx_data, int_enable, rd;
  logic [1:0]  tx_flow_mode, sample_sel, fifo_enh;
  logic [15:0] resume_chars, baud_int;
  int          fail_count, n_tests, i;

  uart_modem_flowctl #(.PART_ID(ID_VAL), .PART_REV(REV_VAL)) dut (.ref_clk, .nrst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cts_n, .dsr_n, .ri_n, .cd_n, .dtr_n, .rts_n, .op2_n, .tx_char_busy, .tx_hold,
    .rx_valid, .rx_data, .rx_store, .rx_store_data(), .resume_seen(), .stop_seen,
    .tx_flow_mode, .resume_chars, .stop_chars(), .baud_int, .baud_frac, .sample_sel,
    .prescale_div4(), .xon_any(), .irda_en(), .int_enable, .fifo_enh, .modem_irq, .char_irq);
  modem_partner modem (.ref_clk, .cts_n, .dsr_n, .ri_n, .cd_n);

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; no fixed latency assumed, the watchdog ends a hang
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // one received character; strobes are checked in the following cycle
  task automatic rx_char(input logic [7:0] c, input logic st, input logic sp);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    #1;
    chk(rx_store, st);
    chk(stop_seen, sp);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial
  begin
    #500000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    results;
  end

  // main sequence
  initial
  begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, tx_char_busy, rx_valid} = 6'h0;
    {wb_adr_i, wb_dat_i, rx_data, fail_count, n_tests} = '0;
    wb_sel_i = 4'hF;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(`OFS_SCRATCH_PAD, 8'hFF);
    rdc(`OFS_MODEM_STATUS, 8'h00);
    chk({int_enable, fifo_enh, baud_frac}, 16'h0);
    wr(`OFS_SCRATCH_PAD, 8'hA5);
    wr(6'h06, 8'h00); // misaligned place must not land anywhere
    rdc(`OFS_SCRATCH_PAD, 8'hA5);
    wr(`OFS_DIVISOR_LOW, 8'h34);
    wr(`OFS_DIVISOR_HIGH, 8'h12);
    wr(`OFS_DIVISOR_FRAC, 8'h2B);
    chk(baud_int, 16'h1234);
    rdc(`OFS_DIVISOR_FRAC, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h10);
    for (i = 0; i < 4; i++)
    begin
      wr(`OFS_DIVISOR_FRAC, {2'h0, i[1:0], 4'h7});
      chk(sample_sel, i[1] ? 2'h2 : i[1:0]);
    end
    chk(baud_frac, 4'h7);
    wr(`OFS_INT_ENABLE, 8'h28);
    wr(`OFS_FIFO_CONTROL, 8'h30);
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_INT_ENABLE, 8'h08);
    wr(`OFS_FIFO_CONTROL, 8'h00);
    wr(`OFS_DIVISOR_FRAC, 8'h00);
    chk({int_enable, fifo_enh, baud_frac}, 16'h0A37);
    wr(`OFS_DIVISOR_LOW, 8'h00);
    wr(`OFS_DIVISOR_HIGH, 8'h00);
    rdc(`OFS_PART_ID, ID_VAL);
    wr(`OFS_PART_ID, 8'h00);
    rdc(`OFS_PART_ID, ID_VAL);
    rdc(`OFS_PART_REV, REV_VAL);
    // modem line walk; interrupt enable bit 3 is set
    for (i = 0; i < 8; i++)
    begin
      modem.set_lines(PINS[i]);
      repeat (5) @(posedge ref_clk);
      chk(modem_irq, |STATUS_EXP[i][3:0]);
      rdc(`OFS_MODEM_STATUS, STATUS_EXP[i]);
    end
    wr(`OFS_MODEM_CONTROL, 8'h0B);
    chk({dtr_n, rts_n, op2_n}, 3'h0);
    wr(`OFS_MODEM_CONTROL, 8'h13);
    xfer(1'b0, `OFS_MODEM_STATUS, 8'h00);
    chk(rd & 8'hF0, 8'h30);
    wr(`OFS_MODEM_CONTROL, 8'h1C);
    xfer(1'b0, `OFS_MODEM_STATUS, 8'h00);
    chk(rd & 8'hF0, 8'hC0);
    wr(`OFS_MODEM_CONTROL, 8'h00);
    // auto cts: clear-to-send is already inactive
    tx_char_busy <= 1'b1;
    wr(`OFS_ENH_FEATURE, 8'h90);
    repeat (5) @(posedge ref_clk);
    chk(tx_hold, 1'b0);
    tx_char_busy <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(tx_hold, 1'b1);
    modem.set_lines(4'hE);
    repeat (5) @(posedge ref_clk);
    chk(tx_hold, 1'b0);
    wr(`OFS_RESUME1, 8'h11);
    wr(`OFS_RESUME2, 8'h13);
    wr(`OFS_STOP1, 8'h19);
    wr(`OFS_STOP2, 8'h1A);
    chk(resume_chars, 16'h1113);
    for (i = 0; i < 4; i++)
    begin
      wr(`OFS_ENH_FEATURE, 8'h00);
      wr(`OFS_ENH_FEATURE, {4'h0, i[1:0], 2'h0});
      chk(tx_flow_mode, i[1:0]);
    end
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h02);
    rx_char(8'h19, 1'b1, 1'b1);
    rx_char(8'h1A, 1'b1, 1'b0);
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h01);
    rx_char(8'h1A, 1'b1, 1'b1);
    rx_char(8'h19, 1'b1, 1'b0);
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h0F);
    rx_char(8'h1A, 1'b1, 1'b0);
    rx_char(8'h19, 1'b1, 1'b0);
    rx_char(8'h1A, 1'b1, 1'b1);
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h0B);
    rx_char(8'h13, 1'b1, 1'b0);
    rx_char(8'h1A, 1'b1, 1'b1);
    wr(`OFS_ENH_FEATURE, 8'h10);
    wr(`OFS_INT_STATUS, 8'h30);
    chk(char_irq, 1'b0);
    wr(`OFS_ENH_FEATURE, 8'h31);
    rx_char(8'h1A, 1'b0, 1'b1);
    chk(char_irq, 1'b1);
    rdc(`OFS_INT_STATUS, 8'h30);
    wr(`OFS_INT_STATUS, 8'h30);
    rdc(`OFS_INT_STATUS, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h00);
    wr(`OFS_ENH_FEATURE, 8'h32);
    rx_char(8'h1A, 1'b1, 1'b0);
    rdc(`OFS_INT_STATUS, 8'h10);
    results;
  end
endmodule // test_uart_modem_flowctl
